// file: pkg/scan_regs_pkg.sv
package scan_regs_pkg;
  // chain geometry
  localparam int unsigned CHAIN_LEN      = 196;
  localparam int unsigned ID_LEN         = 32;
  // fixed cell positions
  localparam int unsigned CELL_FLOAT     = 0;
  localparam int unsigned CELL_FS_DIR    = 24;
  localparam int unsigned CELL_FS_OUT    = 25;
  localparam int unsigned CELL_FS_IN     = 26;
  localparam int unsigned CELL_RX_FIRST  = 28;
  localparam int unsigned CELL_RX_POS    = 30;
  localparam int unsigned CELL_TX_FIRST  = 31;
  localparam int unsigned CELL_TX_POS    = 33;
  // identification field layout
  localparam logic [10:0] ID_MAKER       = 11'h0a5; // arbitrary value
  localparam logic [15:0] ID_PART        = 16'h1234; // arbitrary value
  localparam logic [3:0]  ID_VERSION     = 4'h1;     // arbitrary value
  localparam logic [31:0] ID_VALUE       = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // reset values
  localparam logic [CHAIN_LEN-1:0] CHAIN_RST = '0;
  // selected data register
  typedef enum logic [1:0] {SEL_BYPASS, SEL_IDENT, SEL_CHAIN} dr_sel_t;
endpackage

// file: hw/scan_test_regs.sv
`timescale 1ns/1ps
// Contract
// RULE_01: the bypass path is one flip-flop, so serial in reaches serial out one scan clock later.
// RULE_02: bypass is the data path for the bypass, clamp and outputs-float instructions.
// RULE_03: the identification register has a 32-stage shift path and a 32-bit parallel latch.
// RULE_04: the identification register is selected for the id instruction and in test-logic-reset.
// RULE_05: the boundary chain has 196 cells, each with a shift stage and a parallel latch.
// RULE_06: chain cell 0 high floats every output, low lets outputs drive.
// RULE_07: cell 24 sets frame-start pin direction (1 input), cell 25 its output, cell 26 its input.
// RULE_08: cells sit in fixed places, line receive in 28 to 30 and line transmit in 31 to 33.
// RULE_09: bypass and boundary chain are always present, identification is the optional third.
// RULE_10: the id value is bit 0 one, 11 maker bits, 16 part bits and 4 version bits on top.
// RULE_11: shift stages move into parallel latches at the falling scan clock edge of Update-DR.
// RULE_12: a two-way pin has a control cell then output and input cells, the control gates drive.
// RULE_13: the controller shifts the whole chain length before an update.
module scan_test_regs (
  // clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 nrst_i,
  // scan link, sampled from outside
  input  wire logic                                 scan_clock_i,
  input  wire logic                                 scan_serial_in_i,
  // tap state and instruction, from the tap logic on the scan clock
  input  wire logic                                 tap_reset_i,
  input  wire logic                                 capture_dr_i,
  input  wire logic                                 shift_dr_i,
  input  wire logic                                 update_dr_i,
  input  wire logic                                 ins_bypass_i,
  input  wire logic                                 ins_idcode_i,
  input  wire logic                                 ins_chain_i,
  input  wire logic                                 ins_extest_i,
  input  wire logic                                 ins_clamp_i,
  input  wire logic                                 ins_float_i,
  // core side and pin side of the frame-start pin and line pins, and the capture vector
  input  wire logic                                 core_fs_o_i,
  input  wire logic                                 core_fs_oe_n_i,
  input  wire logic [2:0]                           line_rx_i,
  input  wire logic [2:0]                           core_line_tx_i,
  input  wire logic                                 fs_pin_i,
  input  wire logic [scan_regs_pkg::CHAIN_LEN-1:0]  chain_capture_i,
  // outputs
  output logic                                      scan_serial_out_o,
  output logic      [scan_regs_pkg::CHAIN_LEN-1:0]  chain_latch_o,
  output logic      [scan_regs_pkg::ID_LEN-1:0]     ident_latch_o,
  output logic                                      tx_frame_start_pin_o,
  output logic                                      tx_frame_start_pin_oe_n_o,
  output logic      [2:0]                           line_tx_o,
  output logic                                      line_tx_oe_n_o
);
  import scan_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: two flops before any logic looks at a pin
  logic [1:0] sclk_s_ff, sdi_s_ff, trst_s_ff, cap_s_ff, shf_s_ff, upd_s_ff;
  logic       sclk_d_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_s_ff <= '0;
      sdi_s_ff  <= '0;
      trst_s_ff <= 2'h3;
      cap_s_ff  <= '0;
      shf_s_ff  <= '0;
      upd_s_ff  <= '0;
      sclk_d_ff <= '0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[0], scan_clock_i};
      sdi_s_ff  <= {sdi_s_ff[0], scan_serial_in_i};
      trst_s_ff <= {trst_s_ff[0], tap_reset_i};
      cap_s_ff  <= {cap_s_ff[0], capture_dr_i};
      shf_s_ff  <= {shf_s_ff[0], shift_dr_i};
      upd_s_ff  <= {upd_s_ff[0], update_dr_i};
      sclk_d_ff <= sclk_s_ff[1];
    end
  end

  // instruction bits come from the scan clock side, so they are resynchronised
  // too; they only move in Update-IR, long before the next data scan
  logic [5:0] ins_s0_ff, ins_s1_ff;
  logic       is_bypass, is_idcode, is_chain, is_extest, is_clamp, is_float;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ins_s0_ff <= '0;
      ins_s1_ff <= '0;
    end else begin
      ins_s0_ff <= {ins_float_i, ins_clamp_i, ins_extest_i, ins_chain_i, ins_idcode_i,
                    ins_bypass_i};
      ins_s1_ff <= ins_s0_ff;
    end
  end
  assign {is_float, is_clamp, is_extest, is_chain, is_idcode, is_bypass} = ins_s1_ff;

  // pins seen by capture pass two flops as well; the wide flop set is the price
  // of never capturing a half-settled pin
  logic [CHAIN_LEN-1:0] capt_s0_ff, capt_s1_ff;
  logic [2:0]           rx_s0_ff, rx_s1_ff;
  logic                 fs_s0_ff, fs_s1_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capt_s0_ff <= CHAIN_RST;
      capt_s1_ff <= CHAIN_RST;
      rx_s0_ff   <= '0;
      rx_s1_ff   <= '0;
      fs_s0_ff   <= 1'b0;
      fs_s1_ff   <= 1'b0;
    end else begin
      capt_s0_ff <= chain_capture_i;
      capt_s1_ff <= capt_s0_ff;
      rx_s0_ff   <= line_rx_i;
      rx_s1_ff   <= rx_s0_ff;
      fs_s0_ff   <= fs_pin_i;
      fs_s1_ff   <= fs_s0_ff;
    end
  end

  // edge detect on the synchronised scan clock; data and states are held a whole
  // half period, so their sampled copies are steady at either edge
  logic rise, fall;
  assign rise = sclk_s_ff[1] & ~sclk_d_ff;
  assign fall = ~sclk_s_ff[1] & sclk_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // data register selection; the instruction latch is steady outside Update-IR
  dr_sel_t sel;
  always_comb begin
    if (trst_s_ff[1] || is_idcode)
      sel = SEL_IDENT;                                    // RULE_04
    else if (is_chain || is_extest)
      sel = SEL_CHAIN;
    else
      sel = SEL_BYPASS;                                   // RULE_02
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass stage, one bit long
  logic bypass_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      bypass_ff <= 1'b0;
    else if (rise && cap_s_ff[1] && sel == SEL_BYPASS)
      bypass_ff <= 1'b0;
    else if (rise && shf_s_ff[1] && sel == SEL_BYPASS)
      bypass_ff <= sdi_s_ff[1];                           // RULE_01
  end

  ////////////////////////////////////////////////////////////////////////////
  // identification shift path and parallel latch
  logic [ID_LEN-1:0] id_sh_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      id_sh_ff <= ID_VALUE;
    else if (rise && cap_s_ff[1] && sel == SEL_IDENT)
      id_sh_ff <= ID_VALUE;                               // RULE_10
    else if (rise && shf_s_ff[1] && sel == SEL_IDENT)
      id_sh_ff <= {sdi_s_ff[1], id_sh_ff[ID_LEN-1:1]};    // RULE_03
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      ident_latch_o <= ID_VALUE;
    else if (trst_s_ff[1])
      ident_latch_o <= ID_VALUE;                          // RULE_04
    else if (fall && upd_s_ff[1] && sel == SEL_IDENT)
      ident_latch_o <= id_sh_ff;                          // RULE_11
  end

  ////////////////////////////////////////////////////////////////////////////
  // boundary chain: shift stages and parallel latches
  logic [CHAIN_LEN-1:0] ch_sh_ff;
  logic [CHAIN_LEN-1:0] cap_vec;
  always_comb begin
    cap_vec = capt_s1_ff;
    cap_vec[CELL_FS_IN] = fs_s1_ff;                       // RULE_07
    cap_vec[CELL_RX_POS:CELL_RX_FIRST] = rx_s1_ff;        // RULE_08
    cap_vec[CELL_TX_POS:CELL_TX_FIRST] = core_line_tx_i;
    cap_vec[CELL_FS_OUT] = core_fs_o_i;
    cap_vec[CELL_FS_DIR] = core_fs_oe_n_i;
  end

  // capture takes the resynchronised pins and the core's own drive
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      ch_sh_ff <= CHAIN_RST;
    else if (rise && cap_s_ff[1] && sel == SEL_CHAIN)
      ch_sh_ff <= cap_vec;
    else if (rise && shf_s_ff[1] && sel == SEL_CHAIN)
      ch_sh_ff <= {sdi_s_ff[1], ch_sh_ff[CHAIN_LEN-1:1]}; // RULE_05
  end

  // a short shift leaves stale cells; the controller must shift the whole chain
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      chain_latch_o <= CHAIN_RST;
    else if (fall && upd_s_ff[1] && sel == SEL_CHAIN)
      chain_latch_o <= ch_sh_ff;                          // RULE_11 RULE_13
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output changes on the falling scan clock edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      scan_serial_out_o <= 1'b0;
    else if (fall) begin
      unique case (sel)
        SEL_IDENT:  scan_serial_out_o <= id_sh_ff[0];
        SEL_CHAIN:  scan_serial_out_o <= ch_sh_ff[0];
        SEL_BYPASS: scan_serial_out_o <= bypass_ff;       // RULE_01 RULE_09
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: test instructions take the chain latches, float wins over all
  logic test_drive;
  assign test_drive = is_extest | is_clamp;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_frame_start_pin_o      <= 1'b0;
      tx_frame_start_pin_oe_n_o <= 1'b1;
      line_tx_o                 <= '0;
      line_tx_oe_n_o            <= 1'b1;
    end else if (test_drive) begin
      tx_frame_start_pin_o      <= chain_latch_o[CELL_FS_OUT];
      tx_frame_start_pin_oe_n_o <= chain_latch_o[CELL_FS_DIR] |
                                   chain_latch_o[CELL_FLOAT];   // RULE_06 RULE_12
      line_tx_o                 <= chain_latch_o[CELL_TX_POS:CELL_TX_FIRST];
      line_tx_oe_n_o            <= chain_latch_o[CELL_FLOAT];   // RULE_06
    end else begin
      tx_frame_start_pin_o      <= core_fs_o_i;
      tx_frame_start_pin_oe_n_o <= core_fs_oe_n_i | is_float;
      line_tx_o                 <= core_line_tx_i;
      line_tx_oe_n_o            <= is_float;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_bypass_one_stage: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_01
    (rise && shf_s_ff[1] && sel == SEL_BYPASS) |=> bypass_ff == $past(sdi_s_ff[1]))
    else $error("bypass stage did not take serial in");
  a_ident_select: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_04
    trst_s_ff[1] |-> sel == SEL_IDENT)
    else $error("identification not selected in reset state");
  a_float_gates: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_06
    (test_drive && chain_latch_o[CELL_FLOAT]) |=> tx_frame_start_pin_oe_n_o)
    else $error("float cell did not release pin");
  a_update_latch: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_11
    (fall && upd_s_ff[1] && sel == SEL_CHAIN) |=> chain_latch_o == $past(ch_sh_ff))
    else $error("chain latch missed update");
  a_chain_shift: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_05
    (rise && shf_s_ff[1] && sel == SEL_CHAIN) |=> ch_sh_ff[CHAIN_LEN-1] == $past(sdi_s_ff[1]))
    else $error("chain did not shift in");
  a_id_capture: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_10
    (rise && cap_s_ff[1] && sel == SEL_IDENT) |=> id_sh_ff == ID_VALUE && id_sh_ff[0])
    else $error("id value not loaded");
  a_dir_input: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_07
    (test_drive && chain_latch_o[CELL_FS_DIR]) |=> tx_frame_start_pin_oe_n_o)
    else $error("direction cell did not make pin input");
  a_tx_cells: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_08
    test_drive |=> line_tx_o == $past(chain_latch_o[CELL_TX_POS:CELL_TX_FIRST]))
    else $error("line transmit cells not driven");
  a_bypass_select: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_02
    (is_bypass && !trst_s_ff[1]) |-> sel == SEL_BYPASS)
    else $error("bypass not selected for bypass instruction");
  a_tx_float: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_06
    (test_drive && chain_latch_o[CELL_FLOAT]) |=> line_tx_oe_n_o)
    else $error("float cell did not release line transmit");
endmodule

// file: dv/scan_ctl_model.sv
`timescale 1ns/1ps
// behavioural boundary-scan controller; scan clock stands low outside frames
module scan_ctl_model (
  // scan link to the device
  output logic      scan_clock_o,
  output logic      sdi_o,
  output logic      capture_o,
  output logic      shift_o,
  output logic      update_o,
  // serial answer from the device
  input  wire logic sdo_i
);
  initial begin
    {scan_clock_o, sdi_o, capture_o, shift_o, update_o} = 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one dr scan: capture, n shifts, update; levels change 24 ns after a rise
  // so each scan edge sees steady levels on both sides
  task automatic dr_scan(input logic [195:0] din, input int n, output logic [195:0] dout);
    dout = '0;
    capture_o = 1'b1;
    #32;
    for (int i = 0; i <= n; i++) begin
      scan_clock_o = 1'b1;
      #24;
      capture_o = 1'b0;
      shift_o = (i < n);
      sdi_o = (i < n) ? din[i] : ~sdi_o; // released line toggles, never holds
      #8 scan_clock_o = 1'b0;
      #32;
      if (i < n) dout[i] = sdo_i;
    end
    // update gets a frame of its own, since it acts on the falling edge
    update_o = 1'b1;
    #32 scan_clock_o = 1'b1;
    #32 scan_clock_o = 1'b0;
    #32 update_o = 1'b0;
    sdi_o = ~sdi_o;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
module testbench;
  import scan_regs_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, tap_rst = 1'b1, fs_oe_n = 1'b0, fs_pin = 1'b0;
  logic [5:0] ins = 6'h00; // bypass, idcode, chain, extest, clamp, float
  logic [2:0] rx = 3'h0;
  logic [CHAIN_LEN-1:0] cap = '0, v, d;
  wire sck, sdi, cpt, sft, upd, sdo, pin, pin_oe_n, tx_oe_n;
  wire [CHAIN_LEN-1:0] latch;
  wire [ID_LEN-1:0] ident;
  wire [2:0] tx;
  int n_fail = 0, n_checks = 0, cyc = 0;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  scan_ctl_model u_ctl (.scan_clock_o(sck), .sdi_o(sdi), .capture_o(cpt), .shift_o(sft),
    .update_o(upd), .sdo_i(sdo));
  scan_test_regs u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .scan_clock_i(sck),
    .scan_serial_in_i(sdi), .tap_reset_i(tap_rst), .capture_dr_i(cpt), .shift_dr_i(sft),
    .update_dr_i(upd), .ins_bypass_i(ins[0]), .ins_idcode_i(ins[1]), .ins_chain_i(ins[2]),
    .ins_extest_i(ins[3]), .ins_clamp_i(ins[4]), .ins_float_i(ins[5]),
    .core_fs_o_i(1'b0), .core_fs_oe_n_i(fs_oe_n), .line_rx_i(rx), .core_line_tx_i(3'h2),
    .fs_pin_i(fs_pin), .chain_capture_i(cap), .scan_serial_out_o(sdo),
    .chain_latch_o(latch), .ident_latch_o(ident), .tx_frame_start_pin_o(pin),
    .tx_frame_start_pin_oe_n_o(pin_oe_n), .line_tx_o(tx), .line_tx_oe_n_o(tx_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  // hang guard; a full run needs well under 15000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // instructions only change while the scan link is idle
  task automatic set_ins(input logic [5:0] s);
    @(negedge clk_i) ins = s;
    repeat (4) @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ident();
    `CHK("ident after reset", ID_VALUE, ident)
    @(negedge clk_i) tap_rst = 1'b0;
    set_ins(6'h02);
    u_ctl.dr_scan(196'h5a3c96e1, ID_LEN, d);
    `CHK("ident shifted", ID_VALUE, d[ID_LEN-1:0])
    `CHK("ident latch", 32'h5a3c96e1, ident)
    // back in test-logic-reset the code is forced onto the latch again
    @(negedge clk_i) tap_rst = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK("ident in reset", ID_VALUE, ident)
    @(negedge clk_i) tap_rst = 1'b0;
    $display("test ident done");
  endtask
  // bypass, clamp and float all give the one-stage path, capture 0 first
  task automatic t_bypass();
    logic [5:0] sel[3] = '{6'h01, 6'h10, 6'h20};
    for (int k = 0; k < 3; k++) begin
      set_ins(sel[k]);
      u_ctl.dr_scan({188'h0, 8'h96}, 8, d);
      `CHK("bypass path", 8'h2c, d[7:0])
      `CHK("pin oe_n", k == 2, pin_oe_n)
      `CHK("line tx oe_n", k == 2, tx_oe_n)
      `CHK("line tx", (k == 1) ? 3'h0 : 3'h2, tx)
    end
    `CHK("float oe_n", 1'b1, pin_oe_n)
    $display("test bypass done");
  endtask
  task automatic t_chain();
    v = '0;
    v[CELL_FS_OUT] = 1'b1;
    v[CELL_TX_POS:CELL_TX_FIRST] = 3'h5;
    set_ins(6'h08);
    u_ctl.dr_scan(v, CHAIN_LEN, d);
    `CHK("chain latches", v, latch)
    `CHK("fs pin drive", 1'b0, pin_oe_n)
    `CHK("fs pin value", 1'b1, pin)
    `CHK("line tx", 3'h5, tx)
    // sample the pins, preload a float, then extest must release all drive
    @(negedge clk_i) begin rx = 3'h6; fs_pin = 1'b1; cap = {CHAIN_LEN{1'b1}}; end
    v[CELL_FLOAT] = 1'b1;
    set_ins(6'h04);
    u_ctl.dr_scan(v, CHAIN_LEN, d);
    `CHK("rx cells", 3'h6, d[CELL_RX_POS:CELL_RX_FIRST])
    `CHK("fs in cell", 1'b1, d[CELL_FS_IN])
    `CHK("fs out cell", 1'b0, d[CELL_FS_OUT])
    `CHK("fs dir cell", 1'b0, d[CELL_FS_DIR])
    `CHK("tx cells", 3'h2, d[CELL_TX_POS:CELL_TX_FIRST])
    `CHK("preload", v, latch)
    `CHK("sample keeps drive", 1'b0, pin_oe_n)
    set_ins(6'h08);
    `CHK("global float", 1'b1, pin_oe_n)
    `CHK("line tx float", 1'b1, tx_oe_n)
    // direction cell alone turns the frame-start pin round
    v[CELL_FLOAT] = 1'b0;
    v[CELL_FS_DIR] = 1'b1;
    u_ctl.dr_scan(v, CHAIN_LEN, d);
    `CHK("fs pin input", 1'b1, pin_oe_n)
    `CHK("line tx drive", 1'b0, tx_oe_n)
    $display("test chain done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i) nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_ident();
    t_bypass();
    t_chain();
    end_sim();
  end
endmodule
